// >>> logic/fdrs_pkg.sv
package fdrs_pkg;

  localparam logic [2:0] FDRS_OFS_FIFO = 3'h5;
  localparam logic [2:0] FDRS_OFS_DIAG = 3'h7;
  localparam logic [2:0] FDRS_OFS_RATE = 3'h4;
  localparam logic [2:0] FDRS_OFS_DOUT = 3'h2;

  localparam logic [1:0] FDRS_RATE_RST = 2'h2;
  localparam logic [1:0] FDRS_RATE_500K = 2'h0;
  localparam logic [1:0] FDRS_RATE_300K = 2'h1;
  localparam logic [1:0] FDRS_RATE_250K = 2'h2;
  localparam logic [1:0] FDRS_RATE_1M = 2'h3;
  localparam logic FDRS_PRECOMP_DISABLE_RST = 1'b0;
  localparam logic FDRS_DMA_IRQ_ENABLE_VIEW_RST = 1'b0;
  localparam logic FDRS_FIFO_EN_RST = 1'b0;

  localparam int FDRS_DIAG_CHG_BIT = 7;
  localparam int FDRS_DOUT_DMA_IRQ_ENABLE_VIEW_BIT = 3;
  localparam int FDRS_CC_PRECOMP_DISABLE_BIT = 2;

  localparam logic [1:0] FDRS_CC_NORMAL = 2'h0;
  localparam logic [1:0] FDRS_CC_ABNORMAL = 2'h1;
  localparam logic [1:0] FDRS_CC_INVALID = 2'h2;
  localparam logic [1:0] FDRS_CC_READY_CHG = 2'h3;

  localparam logic [6:0] FDRS_RECAL_STEPS = 7'h4D;
  localparam logic [7:0] FDRS_ZERO_BYTE = 8'h00;
  localparam logic [3:0] FDRS_ONES_NIBBLE = 4'hF;
  localparam logic [2:0] FDRS_ZERO_TRIPLE = 3'h0;

  // Compatibility modes of the diagnostic register
  typedef enum logic [1:0] {
    FDRS_MODE_BASE = 2'h0,
    FDRS_MODE_ENH = 2'h1,
    FDRS_MODE_THIRD = 2'h2
  } fdrs_mode_type;

  // Events reported by the command sequencer at command end
  typedef struct packed {
    logic done;
    logic [1:0] completion_code;
    logic seek_done;
    logic drive_fault;
    logic end_of_track;
    logic id_crc_fail;
    logic data_field_crc_fail;
    logic overrun;
    logic sector_missing;
    logic write_protected_hit;
    logic addr_mark_missing;
    logic control_mark;
    logic wrong_cyl;
    logic scan_equal_hit;
    logic scan_unsatisfied;
    logic bad_cyl;
    logic data_mark_missing;
  } fdrs_event_type;

  typedef struct packed {
    logic fault;
    logic write_prot;
    logic ready;
    logic track0;
    logic two_side;
  } fdrs_drive_type;

endpackage

// >>> logic/fdrs_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Offset five carries command bytes in and result status bytes out, one per access.
// - FIFO mode stays disabled after reset until the configure command enables it.
// - Status zero bits 7-6 hold the completion code of the last command.
// - Status zero bit 4 flags fault or 77 steps without track zero; bit 5 seek done.
// - Status zero bit 3 shows drive not ready; bit 2 shows head address.
// - Status zero bits 1-0 show the selected drive, A through D.
// - Status one bit 7 marks end of cylinder; bits 6 and 3 read zero.
// - Status one bit 5 marks a CRC error in ID or data field.
// - Status one bit 4 marks a host overrun during data transfer.
// - Status one bit 2 marks a sector that could not be found.
// - Status one bit 1 marks write protection hit during write data.
// - Status one bit 0 marks a missing or deleted data address mark.
// - Status two bit 6 is the control mark flag; bit 7 reads zero.
// - Status two bit 5 marks a CRC error in the data field.
// - Status two bit 3 marks scan equal hit, bit 2 scan not satisfied.
// - Status two bit 0 marks missing data address mark while reading.
// - Offset seven read, base mode: bit 7 inverse of disk changed, rest undriven.
// - Enhanced mode: bits 6-3 ones, rate on 2-1, bit 0 low for high rates.
// - Third mode: disk changed, zeros, DMA enable view, precomp disable, rate.
// - Offset seven write sets rate bits 1-0, default binary 10; upper bits zero.
// - Third mode: offset seven bit 2 disables precompensation, reset to zero.
// - The most recent write to either rate register sets the data rate.
// - Rate code: 00 500K, 01 300K, 10 250K, 11 1M.
module fdrs_regs
  import fdrs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [2:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire fdrs_mode_type mode_i,
  input wire logic disk_changed_n,
  input wire logic [1:0] drive_sel_i,
  input wire logic head_addr_i,
  input wire fdrs_drive_type drive_i,
  input wire logic step_pulse_i,
  input wire logic recal_start_i,
  input wire fdrs_event_type evt_i,
  input wire logic configure_i,
  input wire logic fifo_en_val_i,
  output logic [7:0] rdata_o,
  output logic rdata_oe_o,
  output logic [7:0] cmd_byte_o,
  output logic cmd_valid_o,
  output logic [1:0] rate_o,
  output logic precomp_disable_o,
  output logic fifo_enable_o,
  output logic [7:0] status_zero_o,
  output logic [7:0] status_one_o,
  output logic [7:0] status_two_o
);

  logic [7:0] st0_r, st1_r, st2_r;
  logic [1:0] ptr_r;
  logic [1:0] rate_r;
  logic nopre_r;
  logic dma_irq_enable_view_r;
  logic fifo_en_r;
  logic [6:0] steps_r;
  logic recal_r;
  logic [7:0] st3;
  logic [7:0] res_byte;
  logic [7:0] diag;
  logic diag_oe;
  logic high_density_n;

  wire logic rd_fifo = ce_i && rd_i && addr_i == FDRS_OFS_FIFO;
  wire logic rd_diag = ce_i && rd_i && addr_i == FDRS_OFS_DIAG;
  wire logic wr_cc = ce_i && wr_i && addr_i == FDRS_OFS_DIAG;
  wire logic wr_dr = ce_i && wr_i && addr_i == FDRS_OFS_RATE;
  wire logic wr_do = ce_i && wr_i && addr_i == FDRS_OFS_DOUT;
  wire logic recal_timeout = recal_r && steps_r == FDRS_RECAL_STEPS && !drive_i.track0;

  ////////////////////////////////////////////////////////////////////////////
  // Step counter for recalibrate timeout
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      steps_r <= 7'h00;
      recal_r <= 1'b0;
    end else if (ce_i) begin
      if (recal_start_i) begin
        steps_r <= 7'h00;
        recal_r <= 1'b1;
      end else if (evt_i.done) begin
        recal_r <= 1'b0;
      end else if (step_pulse_i && recal_r && steps_r != FDRS_RECAL_STEPS) begin
        steps_r <= steps_r + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result status capture at command end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st0_r <= FDRS_ZERO_BYTE;
    end else if (ce_i && evt_i.done) begin
      st0_r[7:6] <= evt_i.completion_code;
      st0_r[5] <= evt_i.seek_done;
      st0_r[4] <= drive_i.fault || evt_i.drive_fault || recal_timeout;
      st0_r[3] <= !drive_i.ready;
      st0_r[2] <= head_addr_i;
      st0_r[1:0] <= drive_sel_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st1_r <= FDRS_ZERO_BYTE;
    end else if (ce_i && evt_i.done) begin
      st1_r[7] <= evt_i.end_of_track;
      st1_r[6] <= 1'b0;
      st1_r[3] <= 1'b0;
      st1_r[5] <= evt_i.id_crc_fail || evt_i.data_field_crc_fail;
      st1_r[4] <= evt_i.overrun;
      st1_r[2] <= evt_i.sector_missing;
      st1_r[1] <= evt_i.write_protected_hit;
      st1_r[0] <= evt_i.addr_mark_missing;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st2_r <= FDRS_ZERO_BYTE;
    end else if (ce_i && evt_i.done) begin
      st2_r[7] <= 1'b0;
      st2_r[6] <= evt_i.control_mark;
      st2_r[5] <= evt_i.data_field_crc_fail;
      st2_r[4] <= evt_i.wrong_cyl;
      st2_r[3] <= evt_i.scan_equal_hit;
      st2_r[2] <= evt_i.scan_unsatisfied;
      st2_r[1] <= evt_i.bad_cyl;
      st2_r[0] <= evt_i.data_mark_missing;
    end
  end

  // Drive status is live, so status three always shows the present drive
  assign st3 = {drive_i.fault, drive_i.write_prot, drive_i.ready, drive_i.track0,
                drive_i.two_side, head_addr_i, drive_sel_i};

  ////////////////////////////////////////////////////////////////////////////
  // Result stack pointer; a new result restarts at status zero
  // one stacked byte per read
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ptr_r <= 2'h0;
    end else if (ce_i) begin
      if (evt_i.done) begin
        ptr_r <= 2'h0;
      end else if (rd_fifo) begin
        ptr_r <= ptr_r + 2'h1;
      end
    end
  end

  always_comb begin
    case (ptr_r)
      2'h0: res_byte = st0_r;
      2'h1: res_byte = st1_r;
      2'h2: res_byte = st2_r;
      default: res_byte = st3;
    endcase
  end

  // command and parameter bytes pass through
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cmd_byte_o <= FDRS_ZERO_BYTE;
      cmd_valid_o <= 1'b0;
    end else if (ce_i) begin
      cmd_valid_o <= wr_i && addr_i == FDRS_OFS_FIFO;
      if (wr_i && addr_i == FDRS_OFS_FIFO) begin
        cmd_byte_o <= wdata_i;
      end
    end
  end

  // FIFO mode held off until configure
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fifo_en_r <= FDRS_FIFO_EN_RST;
    end else if (ce_i && configure_i) begin
      fifo_en_r <= fifo_en_val_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate, precompensation and DMA enable view
  // last writer of either register wins
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rate_r <= FDRS_RATE_RST;
    end else if (ce_i && (wr_cc || wr_dr)) begin
      rate_r <= wdata_i[1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      nopre_r <= FDRS_PRECOMP_DISABLE_RST;
    end else if (wr_cc && mode_i == FDRS_MODE_THIRD) begin
      nopre_r <= wdata_i[FDRS_CC_PRECOMP_DISABLE_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dma_irq_enable_view_r <= FDRS_DMA_IRQ_ENABLE_VIEW_RST;
    end else if (wr_do) begin
      dma_irq_enable_view_r <= wdata_i[FDRS_DOUT_DMA_IRQ_ENABLE_VIEW_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostic register view
  // high rates are 500K and 1M
  assign high_density_n = !(rate_r == FDRS_RATE_500K || rate_r == FDRS_RATE_1M);

  always_comb begin
    diag = FDRS_ZERO_BYTE;
    diag_oe = 1'b1;
    case (mode_i)
      FDRS_MODE_ENH: begin
        diag = {!disk_changed_n, FDRS_ONES_NIBBLE, rate_r, high_density_n};
      end
      FDRS_MODE_THIRD: begin
        diag = {disk_changed_n, FDRS_ZERO_TRIPLE, dma_irq_enable_view_r, nopre_r, rate_r};
      end
      default: begin
        diag[FDRS_DIAG_CHG_BIT] = !disk_changed_n;
        diag_oe = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered read data; oe low means bits 6-0 float in base mode
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= FDRS_ZERO_BYTE;
      rdata_oe_o <= 1'b0;
    end else if (ce_i) begin
      rdata_oe_o <= 1'b0;
      if (rd_fifo) begin
        rdata_o <= res_byte;
        rdata_oe_o <= 1'b1;
      end else if (rd_diag) begin
        rdata_o <= diag;
        rdata_oe_o <= diag_oe;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rate_o <= FDRS_RATE_RST;
      precomp_disable_o <= FDRS_PRECOMP_DISABLE_RST;
      fifo_enable_o <= FDRS_FIFO_EN_RST;
      status_zero_o <= FDRS_ZERO_BYTE;
      status_one_o <= FDRS_ZERO_BYTE;
      status_two_o <= FDRS_ZERO_BYTE;
    end else if (ce_i) begin
      rate_o <= rate_r;
      precomp_disable_o <= nopre_r;
      fifo_enable_o <= fifo_en_r;
      status_zero_o <= st0_r;
      status_one_o <= st1_r;
      status_two_o <= st2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  rate_default_a: assert property (@(posedge mclk_i)
    $past(rst_i) |-> rate_r == FDRS_RATE_RST)
    else $error("rate not 10 after reset");
  rate_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && (wr_cc || wr_dr) |=> rate_r == $past(wdata_i[1:0]))
    else $error("rate not taken from last write");
  code_capture_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && evt_i.done |=> st0_r[7:6] == $past(evt_i.completion_code))
    else $error("completion code lost");
  st1_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st1_r[6] == 1'b0 && st1_r[3] == 1'b0)
    else $error("status one fixed bits set");
  st2_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st2_r[7] == 1'b0)
    else $error("status two bit 7 set");
  crc_merge_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && evt_i.done && evt_i.id_crc_fail |=> st1_r[5])
    else $error("ID CRC not reported");
  fifo_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !configure_i && !fifo_en_r |=> !fifo_en_r)
    else $error("FIFO enabled without configure");
  // Marks that no result byte has been read since the last command end;
  // lets the check below fire on the real first read, however late it comes
  logic fresh_r;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fresh_r <= 1'b0;
    end else if (ce_i) begin
      if (evt_i.done) begin
        fresh_r <= 1'b1;
      end else if (rd_fifo) begin
        fresh_r <= 1'b0;
      end
    end
  end
  stack_order_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && rd_fifo && fresh_r && !evt_i.done |=> rdata_o == $past(st0_r))
    else $error("first result byte not status zero");
  diag_base_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && rd_diag && mode_i == FDRS_MODE_BASE |=> rdata_o[7] == !$past(disk_changed_n))
    else $error("disk changed bit wrong");
  nopre_mode_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_cc && mode_i != FDRS_MODE_THIRD |=> $stable(nopre_r))
    else $error("precomp disable changed outside third mode");
  seek_end_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && evt_i.done |=> st0_r[5] == $past(evt_i.seek_done))
    else $error("seek end bit lost");
  not_ready_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && evt_i.done |=> st0_r[3] == !$past(drive_i.ready) && st0_r[2] == $past(head_addr_i))
    else $error("ready or head bit wrong");
  unit_sel_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && evt_i.done |=> st0_r[1:0] == $past(drive_sel_i))
    else $error("drive select wrong");
  eot_capture_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && evt_i.done |=> st1_r[7] == $past(evt_i.end_of_track))
    else $error("end of cylinder lost");
  overrun_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && evt_i.done |=> st1_r[4] == $past(evt_i.overrun))
    else $error("overrun lost");
  sector_miss_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && evt_i.done |=> st1_r[2] == $past(evt_i.sector_missing))
    else $error("sector missing lost");
  wprot_hit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && evt_i.done |=> st1_r[1] == $past(evt_i.write_protected_hit))
    else $error("write protect hit lost");
  mark_missing_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && evt_i.done |=> st1_r[0] == $past(evt_i.addr_mark_missing))
    else $error("address mark flag lost");
  data_crc_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && evt_i.done |=> st2_r[5] == $past(evt_i.data_field_crc_fail))
    else $error("data field CRC lost");
  scan_result_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && evt_i.done |=> st2_r[3:2] == $past({evt_i.scan_equal_hit, evt_i.scan_unsatisfied}))
    else $error("scan result lost");

endmodule
`default_nettype wire

// >>> sim/fdrs_host.sv
`timescale 1ns/1ps
`default_nettype none
module fdrs_host
  import fdrs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  input wire logic oe_i,
  output logic ce_o,
  output logic [2:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] wdata_o
);
  initial begin
    ce_o = 1'b1;
    addr_o = 3'h0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end
  // Idle bus flips, so a stale value never passes for a fresh one
  task automatic idle();
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    addr_o = a;
    wdata_o = (a == FDRS_OFS_DIAG) ? (d & 8'h07) : d;
    wr_o = 1'b1;
    @(posedge mclk_i);
    @(negedge mclk_i);
    wr_o = 1'b0;
    idle();
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d, output logic o);
    @(negedge mclk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(posedge mclk_i);
    @(negedge mclk_i);
    d = rdata_i;
    o = oe_i;
    rd_o = 1'b0;
    idle();
  endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import fdrs_pkg::*;
;
  typedef struct packed {
    logic [13:0] f;
    logic [1:0] cc;
    logic sd;
    logic [1:0] sel;
    logic [7:0] s0;
    logic [7:0] s1;
    logic [7:0] s2;
  } fdrs_row_type;
  logic mclk, rst, ce, rd, wr, oe, g_oe, dcn, hd, recal, step, cfg, fen, cv, pd, fe;
  logic [2:0] addr;
  logic [7:0] wd, rdata, cmd, s0, s1, s2, got;
  logic [7:0] ex [4];
  logic [1:0] sel, rate;
  fdrs_mode_type mode;
  fdrs_drive_type drv;
  fdrs_event_type evt;
  fdrs_row_type rows [5];
  int mismatches, tests_run;
  fdrs_host host_u (.mclk_i(mclk), .rdata_i(rdata), .oe_i(oe), .ce_o(ce), .addr_o(addr),
    .rd_o(rd), .wr_o(wr), .wdata_o(wd));
  fdrs_regs dut_u (.mclk_i(mclk), .rst_i(rst), .ce_i(ce), .addr_i(addr), .rd_i(rd),
    .wr_i(wr), .wdata_i(wd), .mode_i(mode), .disk_changed_n(dcn), .drive_sel_i(sel),
    .head_addr_i(hd), .drive_i(drv), .step_pulse_i(step), .recal_start_i(recal),
    .evt_i(evt), .configure_i(cfg), .fifo_en_val_i(fen), .rdata_o(rdata), .rdata_oe_o(oe),
    .cmd_byte_o(cmd), .cmd_valid_o(cv), .rate_o(rate), .precomp_disable_o(pd),
    .fifo_enable_o(fe), .status_zero_o(s0), .status_one_o(s1), .status_two_o(s2));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_1(input logic g, input logic e);
    chk_b({7'h00, g}, {7'h00, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    host_u.rd_reg(a, got, g_oe);
    chk_b(got, e);
  endtask
  task automatic fire(input logic [13:0] f, input logic [1:0] c, input logic sd);
    @(negedge mclk);
    evt = {1'b1, c, sd, f};
    @(negedge mclk);
    evt = '0;
    cyc(3);
  endtask
  task automatic reset_run();
    rst = 1'b1;
    cyc(4);
    rst = 1'b0;
    chk_b({6'h00, rate}, {6'h00, FDRS_RATE_250K});
    chk_1(pd, 1'b0);
    chk_1(fe, 1'b0);
    $display("test reset finished");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    #2000000;
    mismatches++;
    end_sim();
  end
  initial begin
    mode = FDRS_MODE_BASE;
    dcn = 1'b1;
    sel = 2'h0;
    hd = 1'b0;
    drv = 5'h06;
    evt = '0;
    {recal, step, cfg, fen} = 4'h0;
    mismatches = 0;
    tests_run = 0;
    rows[0] = {14'h0000, 2'h0, 1'b1, 2'h0, 8'h20, 8'h00, 8'h00};
    rows[1] = {14'h3000, 2'h1, 1'b0, 2'h1, 8'h51, 8'h80, 8'h00};
    rows[2] = {14'h0A80, 2'h2, 1'b1, 2'h2, 8'hA2, 8'h32, 8'h00};
    rows[3] = {14'h0569, 2'h3, 1'b1, 2'h3, 8'hE3, 8'h25, 8'h69};
    rows[4] = {14'h0016, 2'h0, 1'b1, 2'h0, 8'h20, 8'h00, 8'h16};
    reset_run();
    for (int i = 0; i < 5; i++) begin
      sel = rows[i].sel;
      fire(rows[i].f, rows[i].cc, rows[i].sd);
      ex = '{rows[i].s0, rows[i].s1, rows[i].s2, {drv, hd, rows[i].sel}};
      chk_b(s0, ex[0]);
      chk_b(s1, ex[1]);
      chk_b(s2, ex[2]);
      for (int k = 0; k < 5; k++) begin
        rdc(FDRS_OFS_FIFO, ex[k % 4]);
      end
    end
    $display("test status rows finished");
    // Not ready, head one, track zero never seen
    drv = 5'h00;
    hd = 1'b1;
    sel = 2'h0;
    for (int n = 76; n < 78; n++) begin
      @(negedge mclk);
      recal = 1'b1;
      @(negedge mclk);
      recal = 1'b0;
      repeat (n) begin
        @(negedge mclk);
        step = 1'b1;
        @(negedge mclk);
        step = 1'b0;
      end
      fire(14'h0000, FDRS_CC_ABNORMAL, 1'b0);
      chk_b(s0, (n == 77) ? 8'h5C : 8'h4C);
    end
    drv = 5'h06;
    hd = 1'b0;
    $display("test step count finished");
    host_u.wr_reg(FDRS_OFS_FIFO, 8'hA5);
    chk_1(cv, 1'b1);
    chk_b(cmd, 8'hA5);
    cyc(1);
    chk_1(cv, 1'b0);
    @(negedge mclk);
    fen = 1'b1;
    cfg = 1'b1;
    @(negedge mclk);
    cfg = 1'b0;
    cyc(2);
    chk_1(fe, 1'b1);
    $display("test command and configure finished");
    for (int v = 0; v < 2; v++) begin
      dcn = v[0];
      host_u.rd_reg(FDRS_OFS_DIAG, got, g_oe);
      chk_1(got[7], ~v[0]);
      chk_1(g_oe, 1'b0);
    end
    dcn = 1'b1;
    mode = FDRS_MODE_ENH;
    for (int c = 0; c < 4; c++) begin
      host_u.wr_reg(FDRS_OFS_DIAG, {6'h00, c[1:0]});
      cyc(1);
      chk_b({6'h00, rate}, {6'h00, c[1:0]});
      rdc(FDRS_OFS_DIAG, {5'h0F, c[1:0], ~(c == 0 || c == 3)});
    end
    host_u.wr_reg(FDRS_OFS_RATE, 8'h01);
    cyc(1);
    chk_b({6'h00, rate}, 8'h01);
    host_u.wr_reg(FDRS_OFS_DIAG, 8'h06);
    cyc(1);
    chk_b({6'h00, rate}, 8'h02);
    chk_1(pd, 1'b0);
    mode = FDRS_MODE_THIRD;
    host_u.wr_reg(FDRS_OFS_DIAG, 8'h07);
    host_u.wr_reg(FDRS_OFS_DOUT, 8'h08);
    chk_1(pd, 1'b1);
    rdc(FDRS_OFS_DIAG, 8'h8F);
    host_u.rd_reg(3'h1, got, g_oe);
    chk_b({got[7:1], g_oe}, 8'h8E);
    $display("test diagnostic and rate finished");
    // Clock enable low must freeze the rate against a write
    @(negedge mclk);
    host_u.ce_o = 1'b0;
    host_u.wr_reg(FDRS_OFS_RATE, 8'h00);
    cyc(1);
    chk_b({6'h00, rate}, {6'h00, FDRS_RATE_1M});
    host_u.ce_o = 1'b1;
    $display("test clock enable finished");
    reset_run();
    end_sim();
  end
endmodule
`default_nettype wire
